/* rtl/ocd_top.sv */
// output channel dividers 2 and 3 with their register bank and output routing
`timescale 1ns/1ps
`include "ocd_regs.svh"

////////////////////////////////////////////////////////////////////////////////
// one divider channel: counts, sync, force, phase offset and output routing
module ocd_channel
  import ocd_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] counts,
  input  wire logic [7:0] ctrl,
  input  wire logic [7:0] route,
  input  wire logic       sync,
  input  wire logic [1:0] src_sel,
  input  wire logic       vco_in,
  input  wire logic       clk_in,
  output ocd_group_t      group_out,
  output logic            div_level,
  output ocd_state_t      state
);
  ocd_state_t next_state;
  logic [3:0] cnt;
  logic [3:0] next_cnt;
  logic       level;
  logic       next_level;
  logic       phase_done;
  logic       half_done;
  logic       obey_sync;
  logic       forcing;
  logic       div_out;
  logic       direct_out;
  logic       chan_out;
  logic       use_direct;
  logic       bypass;
  logic       pdown;
  logic       start_high;
  logic       force_level;
  logic [3:0] phase_ofs;
  logic [3:0] high_cnt;
  logic [3:0] low_cnt;

  // field decode
  assign bypass      = ctrl[`OCD_BIT_BYPASS];
  assign obey_sync   = ~ctrl[`OCD_BIT_IGNORE_SYNC];
  // forcing rides on ignore-sync, so a sync pulse can never disturb a static level
  assign forcing     = ctrl[`OCD_BIT_IGNORE_SYNC];
  assign force_level = ctrl[`OCD_BIT_FORCE_HIGH];
  assign start_high  = ctrl[`OCD_BIT_START_HIGH];
  assign phase_ofs   = ctrl[3:0];
  assign high_cnt    = counts[3:0];
  assign low_cnt     = counts[7:4];
  assign pdown       = route[`OCD_BIT_POWER_DOWN];
  // the no-effect source code leaves the channel on its divider
  assign use_direct  = route[`OCD_BIT_DIRECT] & (src_sel != `OCD_SRC_NONE);
  // a field value of n lasts n+1 input cycles
  assign half_done  = level ? (cnt == high_cnt)
                            : (cnt == low_cnt);
  assign phase_done = (cnt == phase_ofs);

  // next state: sync holds the divider, the offset delays release
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_level = level;
    if (obey_sync && sync) begin
      next_state = OCD_ST_HOLD;
      next_cnt   = 4'h0;
      next_level = ctrl[`OCD_BIT_START_HIGH];
    end else begin
      unique case (state)
        OCD_ST_HOLD: begin
          next_state = OCD_ST_DELAY;
          next_cnt   = 4'h0;
          next_level = ctrl[`OCD_BIT_START_HIGH];
        end
        OCD_ST_DELAY: begin
          next_cnt = cnt + 4'h1;
          if (phase_done) begin
            next_state = OCD_ST_RUN;
            next_cnt   = 4'h0;
          end
        end
        OCD_ST_RUN: begin
          // high plus low halves make one period of high+low+2 cycles
          if (half_done) begin
            next_cnt   = 4'h0;
            next_level = ~level;
          end else begin
            next_cnt = cnt + 4'h1;
          end
        end
        default: begin
          next_state = OCD_ST_HOLD;
          next_cnt   = 4'h0;
        end
      endcase
    end
  end

  // counter state; a powered-down or bypassed divider sits in hold
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= OCD_ST_HOLD;
      cnt   <= 4'h0;
      level <= 1'b0;
    end else if (bypass || pdown) begin
      state <= OCD_ST_HOLD;
      cnt   <= 4'h0;
      level <= start_high;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      level <= next_level;
    end
  end

  // divider output: input clock in bypass, forced level while sync ignored, the counted level in run, else the start level.
  // duty correction only matters for odd ratios of an analog edge; in this
  // cycle-based model the counted halves already set the duty cycle.
  assign div_out = bypass ? clk_in
                 : forcing ? force_level
                 : (state == OCD_ST_RUN) ? level
                 : start_high;
  assign direct_out = (src_sel == `OCD_SRC_VCO) ? vco_in
                    : clk_in;
  assign chan_out = pdown ? 1'b0
                  : use_direct ? direct_out
                  : div_out;

  // registered outputs; the status level shows what the divider stage drives
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      group_out <= '0;
      div_level <= 1'b0;
    end else begin
      group_out <= {3{chan_out}};
      div_level <= div_out;
    end
  end
endmodule : ocd_channel

////////////////////////////////////////////////////////////////////////////////
// top: register bank on a plain port and two channels
module ocd_top
  import ocd_pkg::*;
(
  input  wire logic [9:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       sync,
  input  wire logic [1:0] src_sel,
  input  wire logic       vco_in,
  input  wire logic       clk_in,
  output logic            group2_output_a,
  output logic            group2_output_b,
  output logic            group2_output_c,
  output logic            group3_output_a,
  output logic            group3_output_b,
  output logic            group3_output_c,
  output logic            duty_cycle_correction2,
  output logic            duty_cycle_correction3
);
  ocd_bus_t   bus;
  ocd_group_t grp2;
  ocd_group_t grp3;
  ocd_state_t st2;
  ocd_state_t st3;
  logic [7:0] divider2_cycle_counts;
  logic [7:0] divider2_control;
  logic [7:0] channel2_routing_power;
  logic [7:0] divider3_cycle_counts;
  logic [7:0] divider3_control;
  logic [7:0] channel3_routing_power;
  logic [7:0] next_rdata;
  logic       lvl2;
  logic       lvl3;
  logic       hit_div2_counts;
  logic       hit_div2_ctrl;
  logic       hit_ch2_route;
  logic       hit_div3_counts;
  logic       hit_div3_ctrl;
  logic       hit_ch3_route;
  logic       we_div2_counts;
  logic       we_div2_ctrl;
  logic       we_ch2_route;
  logic       we_div3_counts;
  logic       we_div3_ctrl;
  logic       we_ch3_route;
  logic [7:0] rd_ch2_route;
  logic [7:0] rd_ch3_route;
  logic       corr_on2;
  logic       corr_on3;

  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // address decode, shared by the write enables and the read mux
  assign hit_div2_counts = (bus.addr == `OCD_ADDR_DIV2_COUNTS);
  assign hit_div2_ctrl   = (bus.addr == `OCD_ADDR_DIV2_CTRL);
  assign hit_ch2_route   = (bus.addr == `OCD_ADDR_CH2_ROUTE);
  assign hit_div3_counts = (bus.addr == `OCD_ADDR_DIV3_COUNTS);
  assign hit_div3_ctrl   = (bus.addr == `OCD_ADDR_DIV3_CTRL);
  assign hit_ch3_route   = (bus.addr == `OCD_ADDR_CH3_ROUTE);

  // write enables; a write to any other address finds no register and is dropped
  assign we_div2_counts = bus.wr & hit_div2_counts;
  assign we_div2_ctrl   = bus.wr & hit_div2_ctrl;
  assign we_ch2_route   = bus.wr & hit_ch2_route;
  assign we_div3_counts = bus.wr & hit_div3_counts;
  assign we_div3_ctrl   = bus.wr & hit_div3_ctrl;
  assign we_ch3_route   = bus.wr & hit_ch3_route;

  // divider 2 cycle counts; the reset value gives two cycles low and two high
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divider2_cycle_counts <= `OCD_RST_DIV2_COUNTS;
    end else if (we_div2_counts) begin
      divider2_cycle_counts <= bus.wdata;
    end
  end

  // divider 2 control byte
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divider2_control <= `OCD_RST_CTRL;
    end else if (we_div2_ctrl) begin
      divider2_control <= bus.wdata;
    end
  end

  // channel 2 routing and power; only bits 2:0 are stored, bits 7:5 read back status and 4:3 read zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      channel2_routing_power <= `OCD_RST_ROUTE;
    end else if (we_ch2_route) begin
      channel2_routing_power <= {5'h00, bus.wdata[2:0]};
    end
  end

  // divider 3 cycle counts; the reset value divides by two
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divider3_cycle_counts <= `OCD_RST_DIV3_COUNTS;
    end else if (we_div3_counts) begin
      divider3_cycle_counts <= bus.wdata;
    end
  end

  // divider 3 control byte; phase offset starts at zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      divider3_control <= `OCD_RST_CTRL;
    end else if (we_div3_ctrl) begin
      divider3_control <= bus.wdata;
    end
  end

  // channel 3 routing and power; same layout as channel 2
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      channel3_routing_power <= `OCD_RST_ROUTE;
    end else if (we_ch3_route) begin
      channel3_routing_power <= {5'h00, bus.wdata[2:0]};
    end
  end

  // routing reads carry divider state in 7:6 and the stage level in 5
  assign rd_ch2_route = {st2, lvl2, 2'h0, channel2_routing_power[2:0]};
  assign rd_ch3_route = {st3, lvl3, 2'h0, channel3_routing_power[2:0]};

  // read mux; unmapped addresses read zero
  assign next_rdata = hit_div2_counts ? divider2_cycle_counts  :
                      hit_div2_ctrl   ? divider2_control       :
                      hit_ch2_route   ? rd_ch2_route           :
                      hit_div3_counts ? divider3_cycle_counts  :
                      hit_div3_ctrl   ? divider3_control       :
                      hit_ch3_route   ? rd_ch3_route           :
                      8'h00;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 8'h00;
    end else begin
      rdata <= bus.rd ? next_rdata : 8'h00;
    end
  end

  // channel 2 feeds the group 2 outputs
  ocd_channel u_ch2 (
    .clk       (clk),
    .arst_n    (arst_n),
    .counts    (divider2_cycle_counts),
    .ctrl      (divider2_control),
    .route     (channel2_routing_power),
    .sync      (sync),
    .src_sel   (src_sel),
    .vco_in    (vco_in),
    .clk_in    (clk_in),
    .group_out (grp2),
    .div_level (lvl2),
    .state     (st2)
  );

  // channel 3 shares sync and sources; each divider releases after its own phase offset
  ocd_channel u_ch3 (
    .clk       (clk),
    .arst_n    (arst_n),
    .counts    (divider3_cycle_counts),
    .ctrl      (divider3_control),
    .route     (channel3_routing_power),
    .sync      (sync),
    .src_sel   (src_sel),
    .vco_in    (vco_in),
    .clk_in    (clk_in),
    .group_out (grp3),
    .div_level (lvl3),
    .state     (st3)
  );

  // outputs come straight from channel flip-flops
  assign group2_output_a = grp2.out_a;
  assign group2_output_b = grp2.out_b;
  assign group2_output_c = grp2.out_c;
  assign group3_output_a = grp3.out_a;
  assign group3_output_b = grp3.out_b;
  assign group3_output_c = grp3.out_c;

  // correction is on while its disable bit is clear
  assign corr_on2 = ~channel2_routing_power[`OCD_BIT_CORR_OFF];
  assign corr_on3 = ~channel3_routing_power[`OCD_BIT_CORR_OFF];

  // correction-active flags, held in flip-flops so they change on the clock like the outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      duty_cycle_correction2 <= 1'b0;
      duty_cycle_correction3 <= 1'b0;
    end else begin
      duty_cycle_correction2 <= corr_on2;
      duty_cycle_correction3 <= corr_on3;
    end
  end
endmodule : ocd_top

/* rtl/ocd_regs.svh */
// register offsets, field positions, reset values and routing codes for the output dividers
//
// Function
// - low time is low field plus one
// - high time is high field plus one
// - bypass passes input clock straight through
// - divider obeys sync unless ignore set
// - forced output follows force bit level
// - start-high bit picks first output level
// - phase offset delays start after sync
// - power-down puts three outputs safe low
// - direct bit clear drives outputs from divider
// - direct set, select 10b routes VCO
// - direct set, select 00b routes clock input
// - duty correction active while disable bit zero
// - direct set, select 01b has no effect
`ifndef OCD_REGS_SVH
`define OCD_REGS_SVH
`define OCD_ADDR_DIV2_CTRL   10'h197
`define OCD_ADDR_CH2_ROUTE   10'h198
`define OCD_ADDR_DIV3_COUNTS 10'h199
`define OCD_ADDR_DIV3_CTRL   10'h19A
`define OCD_ADDR_CH3_ROUTE   10'h19B
`define OCD_ADDR_DIV2_COUNTS 10'h196
`define OCD_BIT_BYPASS       7
`define OCD_BIT_IGNORE_SYNC  6
`define OCD_BIT_FORCE_HIGH   5
`define OCD_BIT_START_HIGH   4
`define OCD_BIT_POWER_DOWN   2
`define OCD_BIT_DIRECT       1
`define OCD_BIT_CORR_OFF     0
`define OCD_RST_DIV2_COUNTS  8'h11
`define OCD_RST_DIV3_COUNTS  8'h00
`define OCD_RST_CTRL         8'h00
`define OCD_RST_ROUTE        8'h00
`define OCD_SRC_CLK          2'h0
`define OCD_SRC_NONE         2'h1
`define OCD_SRC_VCO          2'h2
`endif

/* rtl/ocd_pkg.sv */
// types shared by the output channel divider block
package ocd_pkg;
  typedef enum logic [1:0] {
    OCD_ST_HOLD  = 2'b00,
    OCD_ST_DELAY = 2'b01,
    OCD_ST_RUN   = 2'b10
  } ocd_state_t;

  // register bus request
  typedef struct packed {
    logic [9:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ocd_bus_t;

  // one channel's three clock outputs
  typedef struct packed {
    logic out_a;
    logic out_b;
    logic out_c;
  } ocd_group_t;
endpackage : ocd_pkg

/* bench/ocd_rx_probe.sv */
// receiver model: measures the last high and low run lengths of one clock line
`timescale 1ns/1ps

module ocd_rx_probe (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       line,
  output logic      [7:0] hi_len,
  output logic      [7:0] lo_len
);
  logic [7:0] run;
  logic       last;

  // a run ends on a level change; the receiver only sees whole runs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      run    <= 8'h01;
      last   <= 1'b0;
      hi_len <= 8'h00;
      lo_len <= 8'h00;
    end else begin
      last <= line;
      run  <= (line != last) ? 8'h01 : run + 8'h01;
      if (line != last && last) hi_len <= run;
      if (line != last && !last) lo_len <= run;
    end
  end
endmodule : ocd_rx_probe

/* bench/ocd_chk.sv */
// concurrent checks on the ports of the output divider top
`timescale 1ns/1ps
`include "ocd_regs.svh"

module ocd_chk (
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       rd,
  input wire logic [7:0] rdata,
  input wire logic       group2_output_a,
  input wire logic       group2_output_b,
  input wire logic       group2_output_c,
  input wire logic       group3_output_a,
  input wire logic       group3_output_b,
  input wire logic       group3_output_c,
  input wire logic       duty_cycle_correction2,
  input wire logic       duty_cycle_correction3
);
  logic [7:0] ctl2;
  logic [7:0] rt2;
  logic [7:0] rt3;
  logic [1:0] up;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // shadow bytes follow the bank; up masks the edges where outputs still show reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctl2 <= 8'h00;
      rt2  <= 8'h00;
      rt3  <= 8'h00;
      up   <= 2'h0;
    end else begin
      if (wr && addr == `OCD_ADDR_DIV2_CTRL) ctl2 <= wdata;
      if (wr && addr == `OCD_ADDR_CH2_ROUTE) rt2 <= wdata;
      if (wr && addr == `OCD_ADDR_CH3_ROUTE) rt3 <= wdata;
      if (up != 2'h3) up <= up + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data not zero outside read answer");
  a_group2_same: assert property (
      group2_output_a == group2_output_b && group2_output_b == group2_output_c)
    else $error("group 2 outputs differ");
  a_group3_same: assert property (
      group3_output_a == group3_output_b && group3_output_b == group3_output_c)
    else $error("group 3 outputs differ");
  a_power_down: assert property (
      rt2[2] && $past(rt2[2]) && $past(rt2[2], 2) |-> !group2_output_a)
    else $error("powered-down group 2 output not low");
  a_force_level: assert property (
      (up == 2'h3 && ctl2 == $past(ctl2) && ctl2 == $past(ctl2, 2) && rt2 == $past(rt2)
       && rt2 == $past(rt2, 2) && ctl2[7:6] == 2'b01 && rt2[2:1] == 2'b00)
      |-> group2_output_a == ctl2[5])
    else $error("forced group 2 level wrong");
  a_corr_two: assert property (
      up == 2'h3 && rt2[0] == $past(rt2[0]) |-> duty_cycle_correction2 == !rt2[0])
    else $error("channel 2 correction flag wrong");
  a_corr_three: assert property (
      up == 2'h3 && rt3[0] == $past(rt3[0]) |-> duty_cycle_correction3 == !rt3[0])
    else $error("channel 3 correction flag wrong");
  a_read_once: assert property (rd ##1 !rd |-> ##1 rdata == 8'h00)
    else $error("read data stood longer than one cycle");
endmodule : ocd_chk

/* bench/tb.sv */
// self-checking bench for the output divider top
`timescale 1ns/1ps
`include "ocd_regs.svh"

module tb;
  logic [9:0] addr = 10'h000;
  logic [7:0] wdata = 8'h00;
  logic       wr = 1'b0, rd = 1'b0, clk = 1'b0, arst_n = 1'b0, sync = 1'b0;
  logic [1:0] src_sel = 2'h0;
  logic       vco_in = 1'b0, clk_in = 1'b0;
  logic       g2a, g2b, g2c, g3a, g3b, g3c, cor2, cor3;
  logic [7:0] rdata, d, hi2, lo2, hi3, lo3, msk;
  int         n_fail = 0, check_count = 0;

  ocd_top i_dut (.addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .clk(clk),
    .arst_n(arst_n), .sync(sync), .src_sel(src_sel), .vco_in(vco_in), .clk_in(clk_in),
    .group2_output_a(g2a), .group2_output_b(g2b), .group2_output_c(g2c),
    .group3_output_a(g3a), .group3_output_b(g3b), .group3_output_c(g3c),
    .duty_cycle_correction2(cor2), .duty_cycle_correction3(cor3));
  ocd_rx_probe i_rx2 (.clk(clk), .arst_n(arst_n), .line(g2a), .hi_len(hi2), .lo_len(lo2));
  ocd_rx_probe i_rx3 (.clk(clk), .arst_n(arst_n), .line(g3a), .hi_len(hi3), .lo_len(lo3));

  initial begin
    forever #25 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr_reg(input logic [9:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task rd_reg(input logic [9:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    v = rdata;
  endtask : rd_reg
  // the inputs are sampled and registered, so a few cycles pass before a level is judged
  task look(input logic exp);
    repeat (5) @(posedge clk);
    @(negedge clk);
    chk({5'h00, g2a, g2b, g2c}, {5'h00, {3{exp}}});
  endtask : look
  task give_verdict;
    $display("comparisons %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : give_verdict

  initial begin
    #(50 * 3000);
    n_fail++;
    give_verdict;
  end

  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    // reset values, routing status bits masked, one unmapped place at the end
    for (int i = 0; i < 7; i++) begin
      rd_reg(10'h196 + 10'(i), d);
      msk = (i == 2 || i == 5) ? 8'h07 : 8'hFF;
      chk(d & msk, (i == 0) ? `OCD_RST_DIV2_COUNTS : 8'h00);
    end
    wr_reg(`OCD_ADDR_DIV2_CTRL, 8'h5A);
    rd_reg(`OCD_ADDR_DIV2_CTRL, d);
    chk(d, 8'h5A);
    $display("test registers done");
    // low 3 cycles, high 2 on channel 2; channel 3 default divides by two
    wr_reg(`OCD_ADDR_DIV2_COUNTS, 8'h21);
    wr_reg(`OCD_ADDR_DIV2_CTRL, 8'h00);
    repeat (40) @(posedge clk);
    @(negedge clk);
    chk(hi2, 8'h02);
    chk(lo2, 8'h03);
    chk(hi3, 8'h01);
    chk(lo3, 8'h01);
    $display("test ratio done");
    // phase 8 keeps the channel in delay for nine cycles after sync falls, start high
    wr_reg(`OCD_ADDR_DIV2_CTRL, 8'h18);
    sync <= 1'b1;
    repeat (3) @(posedge clk);
    sync <= 1'b0;
    rd_reg(`OCD_ADDR_CH2_ROUTE, d);
    chk({6'h00, d[7:6]}, 8'h01);
    chk({7'h00, d[5]}, 8'h01);
    repeat (6) @(posedge clk);
    rd_reg(`OCD_ADDR_CH2_ROUTE, d);
    chk({6'h00, d[7:6]}, 8'h01);
    rd_reg(`OCD_ADDR_CH2_ROUTE, d);
    chk({6'h00, d[7:6]}, 8'h02);
    $display("test phase done");
    // forced levels need ignore-sync set; sync stays high through both forced levels to show it has no hold
    sync <= 1'b1;
    wr_reg(`OCD_ADDR_DIV2_CTRL, 8'h60);
    look(1'b1);
    rd_reg(`OCD_ADDR_CH2_ROUTE, d);
    chk({6'h00, d[7:6]}, 8'h02);
    wr_reg(`OCD_ADDR_DIV2_CTRL, 8'h40);
    look(1'b0);
    sync <= 1'b0;
    wr_reg(`OCD_ADDR_DIV2_CTRL, 8'h80);
    for (int v = 0; v < 2; v++) begin
      clk_in <= v[0];
      look(v[0]);
    end
    $display("test force and bypass done");
    // direct routing for every source code, divider forced low as the reference
    wr_reg(`OCD_ADDR_DIV2_CTRL, 8'h40);
    wr_reg(`OCD_ADDR_CH2_ROUTE, 8'h02);
    for (int s = 0; s < 3; s++) begin
      for (int v = 0; v < 2; v++) begin
        src_sel <= 2'(s);
        vco_in <= v[0];
        clk_in <= !v[0];
        look((s == 2) ? v[0] : (s == 0) ? !v[0] : 1'b0);
      end
    end
    wr_reg(`OCD_ADDR_DIV2_CTRL, 8'h60);
    wr_reg(`OCD_ADDR_CH2_ROUTE, 8'h04);
    look(1'b0);
    wr_reg(`OCD_ADDR_CH3_ROUTE, 8'h01);
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk({7'h00, cor3}, 8'h00);
    chk({7'h00, cor2}, 8'h01);
    $display("test routing done");
    give_verdict;
  end
endmodule : tb

bind ocd_top ocd_chk i_chk (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .group2_output_a(group2_output_a), .group2_output_b(group2_output_b),
  .group2_output_c(group2_output_c), .group3_output_a(group3_output_a),
  .group3_output_b(group3_output_b), .group3_output_c(group3_output_c),
  .duty_cycle_correction2(duty_cycle_correction2),
  .duty_cycle_correction3(duty_cycle_correction3));
